// ===== scl_defines.vh
`ifndef SCL_DEFINES_VH
`define SCL_DEFINES_VH

// register byte offsets, decoded over the low address byte
`define SCL_ADDR_BITS 8
`define SCL_OFF_LED_FUNC 8'h00
`define SCL_OFF_LED_MODE 8'h04
`define SCL_OFF_SIG_DETECT 8'h08
`define SCL_OFF_ADDR 8'h0C
`define SCL_OFF_STRAP 8'h10

// strap code layout, four bits per strap pin
`define SCL_PIN_COUNT 5
`define SCL_CODE_W 4
`define SCL_CODE_RAIL 3
`define SCL_CODE_COMBINE 2
`define SCL_CODE_DETECT_POL 2
`define SCL_CODE_SWAP 1
`define SCL_CODE_COPPER 0

// indicator mode register fields
`define SCL_MODE_COPPER_BIT 15
`define SCL_MODE_STATUS_LSB 0

// signal detect register fields
`define SCL_DETECT_POL_BIT 0
`define SCL_DETECT_STAT_BIT 8

// station address register fields
`define SCL_ADDR_PORT0_LSB 0
`define SCL_ADDR_PORT1_LSB 8
`define SCL_ADDR_SWAP_BIT 16

// reset values of the writable fields before the strap load
`define SCL_RST_LED_FUNC 16'h0000
`define SCL_RST_STATUS_ONLY 4'h0
`define SCL_RST_COPPER_ONLY 1'b0
`define SCL_RST_DETECT_POL 1'b0

// bus responses
`define SCL_RESP_OKAY 2'b00
`define SCL_RESP_SLVERR 2'b10

`endif

// ===== scl_strap_sync.v
// two-stage synchroniser for one strap pin and its sensed resistor step
module scl_strap_sync (
    input wire aclk,
    input wire rail_high,
    input wire [2:0] step,
    output reg [3:0] code
);

    reg [3:0] stage1;

    // first stage feeds only the second
    always @(posedge aclk) begin
        stage1 <= {rail_high, step};
        code <= stage1;
    end

endmodule

// ===== scl_strap_loader.v
// The AXI4-Lite interface to the registers and the placing of the registers are this design's own decisions.
`include "scl_defines.vh"

// How it works
// - pin 4 code bit 2 sets signal-detect polarity default; one means active low.
// - pin 4 code bit 1 swaps which port answers address LSB zero or one.
// - pin 4 code bit 0 sets default copper-only indicator reporting.
// - code bit 2 of pins 3..0 sets each indicator's combine bit default.
// - combine bit one gives steady status only, no activity or collision blinking.
// - code bit 3 of pins 2..0 gives the upper three station address bits.
// - address bit 4 from pin 2, bit 3 from pin 1, bit 2 from pin 0.
// - pin 3 code bits 1:0 set indicator 3 function field default.
// - pin 2 code bits 1:0 set indicator 2 function field default.
// - pin 1 code bits 1:0 set indicator 1 function field default.
// - pin 0 code bits 1:0 set indicator 0 function field default.
// - rail tie sets code bit 3: ground gives zero, supply gives one.
// - resistor step sets code bits 2:0, direct tie giving zero.
// - management writes override the limited strap defaults.
// - with straps grounded every strap setting except address bits and port swap stays writable by software.
// - address bits and port swap come only from straps, never writes.
module scl_strap_loader (
    input wire aclk,
    input wire aresetn,
    input wire [4:0] config_strap_pin_rail,
    input wire [14:0] config_strap_pin_step,
    input wire signal_detect_input,
    output reg signal_detect_active,
    output reg signal_detect_active_low,
    output reg port_address_swap,
    output reg [2:0] station_address_upper,
    output reg [4:0] port0_station_address,
    output reg [4:0] port1_station_address,
    output reg [15:0] indicator_function,
    output reg [3:0] indicator_status_only,
    output reg indicator_copper_only,
    output reg config_loaded,
    input wire [31:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [31:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready
);

    wire [19:0] live_code;
    reg [19:0] held_code;
    reg load_pending;
    reg sd_s1;
    reg sd_s2;

    // per-pin code fields of the captured straps
    wire [3:0] code0;
    wire [3:0] code1;
    wire [3:0] code2;
    wire [3:0] code3;
    wire [3:0] code4;

    assign code0 = held_code[3:0];
    assign code1 = held_code[7:4];
    assign code2 = held_code[11:8];
    assign code3 = held_code[15:12];
    assign code4 = held_code[19:16];

    // strap fields named after the settings they default
    wire strap_detect_pol;
    wire strap_swap;
    wire strap_copper;
    wire [3:0] strap_combine;
    wire [2:0] strap_upper;
    wire [15:0] strap_func;

    assign strap_detect_pol = code4[`SCL_CODE_DETECT_POL];
    assign strap_swap = code4[`SCL_CODE_SWAP];
    assign strap_copper = code4[`SCL_CODE_COPPER];
    assign strap_combine[3] = code3[`SCL_CODE_COMBINE];
    assign strap_combine[2] = code2[`SCL_CODE_COMBINE];
    assign strap_combine[1] = code1[`SCL_CODE_COMBINE];
    assign strap_combine[0] = code0[`SCL_CODE_COMBINE];
    assign strap_upper[2] = code2[`SCL_CODE_RAIL];
    assign strap_upper[1] = code1[`SCL_CODE_RAIL];
    assign strap_upper[0] = code0[`SCL_CODE_RAIL];
    assign strap_func[15:12] = {2'h0, code3[1:0]};
    assign strap_func[11:8] = {2'h0, code2[1:0]};
    assign strap_func[7:4] = {2'h0, code1[1:0]};
    assign strap_func[3:0] = {2'h0, code0[1:0]};

    // one synchroniser per strap pin
    genvar gi;
    generate
        for (gi = 0; gi < `SCL_PIN_COUNT; gi = gi + 1) begin : g_pin
            scl_strap_sync u_sync (
                .aclk(aclk),
                .rail_high(config_strap_pin_rail[gi]),
                .step(config_strap_pin_step[3*gi+2:3*gi]),
                .code(live_code[4*gi+3:4*gi])
            );
        end
    endgenerate

    // sample straps throughout reset, freeze at release
    always @(posedge aclk) begin
        if (!aresetn) begin
            held_code <= live_code;
        end
    end

    // one load cycle right after reset release
    always @(posedge aclk) begin
        if (!aresetn) begin
            load_pending <= 1'b1;
            config_loaded <= 1'b0;
        end else if (load_pending) begin
            load_pending <= 1'b0;
            config_loaded <= 1'b1;
        end
    end

    // strap-only address settings, no bus path reaches them
    always @(posedge aclk) begin
        if (!aresetn) begin
            port_address_swap <= 1'b0;
            station_address_upper <= 3'b000;
            port0_station_address <= 5'b00000;
            port1_station_address <= 5'b00001;
        end else if (load_pending) begin
            port_address_swap <= strap_swap;
            station_address_upper <= strap_upper;
            port0_station_address <= {strap_upper, 1'h0, strap_swap};
            port1_station_address <= {strap_upper, 1'h0, ~strap_swap};
        end
    end

    // bus write bookkeeping
    reg aw_held;
    reg w_held;
    reg [7:0] aw_addr;
    reg [31:0] w_data;
    reg [3:0] w_strb;
    wire do_write;
    wire wr_func;
    wire wr_mode;
    wire wr_sig;
    wire wr_port_addr;
    wire wr_strap_img;
    wire wr_ro;
    wire wr_mapped;

    // decode of the held write address; read-only words answer but keep their value
    assign do_write = aw_held && w_held && !s_axi_bvalid;
    assign wr_func = (aw_addr == `SCL_OFF_LED_FUNC);
    assign wr_mode = (aw_addr == `SCL_OFF_LED_MODE);
    assign wr_sig = (aw_addr == `SCL_OFF_SIG_DETECT);
    assign wr_port_addr = (aw_addr == `SCL_OFF_ADDR);
    assign wr_strap_img = (aw_addr == `SCL_OFF_STRAP);
    assign wr_ro = wr_port_addr || wr_strap_img;
    assign wr_mapped = wr_func || wr_mode || wr_sig || wr_ro;

    // write address channel, accepted only after the strap load
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr <= 8'h00;
            s_axi_awready <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= {s_axi_awaddr[7:2], 2'b00};
                s_axi_awready <= 1'b0;
            end else if (do_write) begin
                aw_held <= 1'b0;
            end else begin
                s_axi_awready <= config_loaded && !aw_held && !s_axi_bvalid;
            end
        end
    end

    // write data channel, taken independently of the address
    always @(posedge aclk) begin
        if (!aresetn) begin
            w_held <= 1'b0;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            s_axi_wready <= 1'b0;
        end else begin
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end else if (do_write) begin
                w_held <= 1'b0;
            end else begin
                s_axi_wready <= config_loaded && !w_held && !s_axi_bvalid;
            end
        end
    end

    // write response once both halves are in
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `SCL_RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_mapped ? `SCL_RESP_OKAY : `SCL_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // byte-lane merges of the writable images, unstrobed lanes keep their value
    wire [15:0] func_merged;
    wire [3:0] status_merged;
    wire copper_merged;
    wire detect_pol_merged;

    assign func_merged = {w_strb[1] ? w_data[15:8] : indicator_function[15:8],
                          w_strb[0] ? w_data[7:0] : indicator_function[7:0]};
    assign status_merged = w_strb[0] ? w_data[`SCL_MODE_STATUS_LSB+3:`SCL_MODE_STATUS_LSB]
                                     : indicator_status_only;
    assign copper_merged = w_strb[1] ? w_data[`SCL_MODE_COPPER_BIT] : indicator_copper_only;
    assign detect_pol_merged = w_strb[0] ? w_data[`SCL_DETECT_POL_BIT]
                                         : signal_detect_active_low;

    // indicator function fields: strap default, then software
    always @(posedge aclk) begin
        if (!aresetn) begin
            indicator_function <= `SCL_RST_LED_FUNC;
        end else if (load_pending) begin
            indicator_function <= strap_func;
        end else if (do_write && wr_func) begin
            indicator_function <= func_merged;
        end
    end

    // indicator combine and copper-only bits
    always @(posedge aclk) begin
        if (!aresetn) begin
            indicator_status_only <= `SCL_RST_STATUS_ONLY;
            indicator_copper_only <= `SCL_RST_COPPER_ONLY;
        end else if (load_pending) begin
            indicator_status_only <= strap_combine;
            indicator_copper_only <= strap_copper;
        end else if (do_write && wr_mode) begin
            indicator_status_only <= status_merged;
            indicator_copper_only <= copper_merged;
        end
    end

    // signal detect polarity control
    always @(posedge aclk) begin
        if (!aresetn) begin
            signal_detect_active_low <= `SCL_RST_DETECT_POL;
        end else if (load_pending) begin
            signal_detect_active_low <= strap_detect_pol;
        end else if (do_write && wr_sig) begin
            signal_detect_active_low <= detect_pol_merged;
        end
    end

    // signal detect pin synchroniser and polarity apply
    always @(posedge aclk) begin
        sd_s1 <= signal_detect_input;
        sd_s2 <= sd_s1;
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            signal_detect_active <= 1'b0;
        end else begin
            signal_detect_active <= sd_s2 ^ signal_detect_active_low;
        end
    end

    // read mux over the low address byte
    reg [31:0] rd_word;
    reg rd_hit;
    wire [7:0] rd_addr;

    assign rd_addr = {s_axi_araddr[7:2], 2'h0};

    always @* begin
        rd_word = 32'h00000000;
        rd_hit = 1'b1;
        case (rd_addr)
            `SCL_OFF_LED_FUNC: begin
                rd_word[15:0] = indicator_function;
            end
            `SCL_OFF_LED_MODE: begin
                rd_word[`SCL_MODE_COPPER_BIT] = indicator_copper_only;
                rd_word[`SCL_MODE_STATUS_LSB+3:`SCL_MODE_STATUS_LSB] = indicator_status_only;
            end
            `SCL_OFF_SIG_DETECT: begin
                rd_word[`SCL_DETECT_POL_BIT] = signal_detect_active_low;
                rd_word[`SCL_DETECT_STAT_BIT] = signal_detect_active;
            end
            `SCL_OFF_ADDR: begin
                rd_word[`SCL_ADDR_PORT0_LSB+4:`SCL_ADDR_PORT0_LSB] = port0_station_address;
                rd_word[`SCL_ADDR_PORT1_LSB+4:`SCL_ADDR_PORT1_LSB] = port1_station_address;
                rd_word[`SCL_ADDR_SWAP_BIT] = port_address_swap;
            end
            `SCL_OFF_STRAP: begin
                rd_word[19:0] = held_code;
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    // read channel, one read at a time
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `SCL_RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_hit ? `SCL_RESP_OKAY : `SCL_RESP_SLVERR;
            end else if (s_axi_rvalid) begin
                if (s_axi_rready) begin
                    s_axi_rvalid <= 1'b0;
                end
            end else begin
                s_axi_arready <= config_loaded;
            end
        end
    end

endmodule

// ===== scl_strap_board.sv
// board-side strap resistors: a 4-bit code per pin becomes a rail tie and a step
module scl_strap_board (
    input wire logic [19:0] strap_codes,
    output logic [4:0] rail,
    output logic [14:0] step
);
    timeunit 1ns;
    timeprecision 1ps;
    // code bit 3 picks the rail, bits 2:0 pick the resistor step
    always_comb begin
        for (int i = 0; i < 5; i++) begin
            rail[i] = strap_codes[4*i+3];
            step[3*i +: 3] = strap_codes[4*i +: 3];
        end
    end
endmodule

// ===== scl_strap_loader_assertions.sv
// port-level checks of the strap loader
module scl_strap_loader_assertions (
    input wire aclk,
    input wire aresetn,
    input wire [4:0] config_strap_pin_rail,
    input wire [14:0] config_strap_pin_step,
    input wire signal_detect_active_low,
    input wire port_address_swap,
    input wire [2:0] station_address_upper,
    input wire [4:0] port0_station_address,
    input wire [4:0] port1_station_address,
    input wire [15:0] indicator_function,
    input wire [3:0] indicator_status_only,
    input wire indicator_copper_only,
    input wire config_loaded,
    input wire s_axi_awready,
    input wire s_axi_arready,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_rvalid,
    input wire s_axi_rready
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_load_once;
        $rose(aresetn) |-> !config_loaded ##1 config_loaded;
    endproperty
    a_load_once: assert property (p_load_once) else $error("late strap load");
    property p_pin4;
        $rose(config_loaded) |-> signal_detect_active_low == config_strap_pin_step[14]
            && port_address_swap == config_strap_pin_step[13]
            && indicator_copper_only == config_strap_pin_step[12];
    endproperty
    a_pin4: assert property (p_pin4) else $error("pin 4 defaults wrong");
    property p_func;
        $rose(config_loaded) |-> indicator_function == {2'h0, config_strap_pin_step[10:9],
            2'h0, config_strap_pin_step[7:6], 2'h0, config_strap_pin_step[4:3],
            2'h0, config_strap_pin_step[1:0]};
    endproperty
    a_func: assert property (p_func) else $error("function defaults wrong");
    property p_status;
        $rose(config_loaded) |-> indicator_status_only == {config_strap_pin_step[11],
            config_strap_pin_step[8], config_strap_pin_step[5], config_strap_pin_step[2]};
    endproperty
    a_status: assert property (p_status) else $error("combine defaults wrong");
    property p_upper;
        $rose(config_loaded) |-> station_address_upper == config_strap_pin_rail[2:0];
    endproperty
    a_upper: assert property (p_upper) else $error("upper address wrong");
    property p_ports;
        config_loaded |-> port0_station_address == {station_address_upper, 1'h0, port_address_swap}
            && port1_station_address == {station_address_upper, 1'h0, !port_address_swap};
    endproperty
    a_ports: assert property (p_ports) else $error("port addresses wrong");
    property p_held;
        config_loaded && $past(config_loaded) |->
            $stable(station_address_upper) && $stable(port_address_swap);
    endproperty
    a_held: assert property (p_held) else $error("strap address changed");
    property p_no_early;
        !config_loaded |-> !s_axi_awready && !s_axi_arready;
    endproperty
    a_no_early: assert property (p_no_early) else $error("bus served before load");
    property p_aw_return;
        s_axi_bvalid && s_axi_bready |=> !s_axi_awready ##1 s_axi_awready;
    endproperty
    a_aw_return: assert property (p_aw_return) else $error("awready return wrong");
    property p_ar_return;
        s_axi_rvalid && s_axi_rready |-> ##[1:2] s_axi_arready;
    endproperty
    a_ar_return: assert property (p_ar_return) else $error("arready return wrong");
endmodule
bind scl_strap_loader scl_strap_loader_assertions scl_strap_loader_assertions_i (.aclk,
    .aresetn, .config_strap_pin_rail, .config_strap_pin_step, .signal_detect_active_low,
    .port_address_swap, .station_address_upper, .port0_station_address,
    .port1_station_address, .indicator_function, .indicator_status_only,
    .indicator_copper_only, .config_loaded, .s_axi_awready, .s_axi_arready, .s_axi_bvalid,
    .s_axi_bready, .s_axi_rvalid, .s_axi_rready);

// ===== scl_strap_loader_tb.sv
// strap configurations loaded through reset, then overridden over the bus
module scl_strap_loader_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 1'h0, aresetn = 1'h0, sig_in = 1'h0;
    logic [19:0] codes = 20'h00000;
    logic [4:0] rail;
    logic [14:0] step;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int errors = 0, check_count = 0, cycles = 0;
    always #12.5 aclk = ~aclk;
    scl_strap_board scl_strap_board_i (.strap_codes(codes), .rail(rail), .step(step));
    scl_strap_loader scl_strap_loader_i (.aclk, .aresetn, .config_strap_pin_rail(rail),
        .config_strap_pin_step(step), .signal_detect_input(sig_in), .signal_detect_active(),
        .signal_detect_active_low(), .port_address_swap(), .station_address_upper(),
        .port0_station_address(), .port1_station_address(), .indicator_function(),
        .indicator_status_only(), .indicator_copper_only(), .config_loaded(), .s_axi_awaddr,
        .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    // counts and verdict
    task automatic conclude;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    // one write: address and data offered together, each released when taken
    task automatic wr(logic [31:0] a, logic [31:0] d, logic [1:0] er, string name);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'h0;
        chk(name, {30'h0, er}, {30'h0, s_axi_bresp});
        repeat (2) @(posedge aclk);
    endtask
    // one read, data and response taken at the rvalid edge
    task automatic rd(logic [31:0] a, logic [31:0] exp, logic [1:0] er, string name);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'h0;
        chk(name, exp, s_axi_rdata);
        chk(name, {30'h0, er}, {30'h0, s_axi_rresp});
        repeat (2) @(posedge aclk);
    endtask
    // reset with new straps, check defaults, then override from software
    task automatic run_config(logic [19:0] c, logic s);
        logic [31:0] addr_word;
        addr_word = {15'h0, c[17], 3'h0, c[11], c[7], c[3], 1'h0, !c[17],
            3'h0, c[11], c[7], c[3], 1'h0, c[17]};
        @(posedge aclk);
        codes <= c;
        sig_in <= s;
        aresetn <= 1'h0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'h1;
        rd(32'h10, {12'h0, c}, 2'h0, "strap");
        rd(32'h0, {16'h0, 2'h0, c[13:12], 2'h0, c[9:8], 2'h0, c[5:4], 2'h0, c[1:0]},
            2'h0, "func");
        rd(32'h4, {16'h0, c[16], 11'h0, c[14], c[10], c[6], c[2]}, 2'h0, "mode");
        rd(32'h8, {23'h0, s ^ c[18], 7'h0, c[18]}, 2'h0, "detect");
        rd(32'hC, addr_word, 2'h0, "addr");
        wr(32'h0, 32'hFFFFFFFF, 2'h0, "wr func");
        rd(32'h0, 32'h0000FFFF, 2'h0, "func ovr");
        s_axi_wstrb <= 4'h1;
        wr(32'h0, 32'h0, 2'h0, "wr func lane");
        s_axi_wstrb <= 4'hF;
        rd(32'h0, 32'h0000FF00, 2'h0, "func lane");
        wr(32'h4, 32'hFFFFFFFF, 2'h0, "wr mode");
        rd(32'h4, 32'h0000800F, 2'h0, "mode ovr");
        wr(32'h8, {31'h0, !c[18]}, 2'h0, "wr detect");
        rd(32'h8, {23'h0, s ^ !c[18], 7'h0, !c[18]}, 2'h0, "detect ovr");
        wr(32'hC, 32'hFFFFFFFF, 2'h0, "wr addr");
        rd(32'hC, addr_word, 2'h0, "addr kept");
        wr(32'h14, 32'hFFFFFFFF, 2'h2, "wr unmapped");
        rd(32'h14, 32'h0, 2'h2, "rd unmapped");
        $display("test config %h done", c);
    endtask
    // hang guard
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            conclude();
        end
    end
    initial begin
        logic [19:0] c;
        run_config(20'h00000, 1'h0);
        for (int k = 0; k < 4; k++) begin
            for (int i = 0; i < 5; i++) c[4*i +: 4] = 4'(k * 7 + i * 5);
            run_config(c, k[0]);
        end
        conclude();
    end
endmodule
